// File: design/msc_consts.vh
/*
 * Constants for the mode and system control block: register offsets,
 * field positions, reset values and settling-wait counts.
 * Assumes a 32-bit AXI4-Lite slave and a 125 MHz system clock.
 */
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH
`define MSC_OFS_MODE_STATUS 16'hFFF1
`define MSC_OFS_SYSCTRL 16'hFFF2
`define MSC_OFS_SLEEP_CTRL 16'hFFF4
`define MSC_ADDR_MODE_STATUS 18'h3FFC4
`define MSC_ADDR_SYSCTRL 18'h3FFC8
`define MSC_ADDR_SLEEP_CTRL 18'h3FFD0
`define MSC_SYSCTRL_RESET 8'h0B
`define MSC_MODE_STATUS_FIXED 8'hC0
`define MSC_BIT_STANDBY 7
`define MSC_BIT_WAIT_HI 6
`define MSC_BIT_WAIT_LO 4
`define MSC_BIT_USER_EN 3
`define MSC_BIT_EDGE 2
`define MSC_BIT_RSVD 1
`define MSC_BIT_RAM_EN 0
`define MSC_WAIT_0 19'h02000
`define MSC_WAIT_1 19'h04000
`define MSC_WAIT_2 19'h08000
`define MSC_WAIT_3 19'h10000
`define MSC_WAIT_4 19'h20000
`define MSC_WAIT_5 19'h40000
`define MSC_WAIT_6 19'h00400
`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_SLVERR 2'h2
`endif

// File: design/msc_mode_decode.v
/*
 * Mode decode: turns the three synchronised mode pin levels and the area
 * width settings into mode number, address size, rom/ram use and bus width.
 * Assumes the pins are already synchronised to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module msc_mode_decode (
  input wire [2:0] mode_code, // synchronised mode pin levels
  input wire ram_enable, // ram enable bit of system control
  input wire [7:0] area_width_config, // 1 per area means 16-bit access
  output reg [2:0] mode_num, // 1..7, 0 for undefined strap
  output reg mode_valid, // strap is one of the seven modes
  output reg addr_16m, // 16 Mbyte address space
  output reg rom_enabled, // on-chip rom visible
  output reg ext_bus_en, // external bus allowed
  output reg init_bus16, // initial bus width is 16 bits
  output reg bus16_now, // present external data bus width 16 bits
  output reg ram_on // on-chip ram answers its range
);
  always @* begin
    mode_num = mode_code;
    mode_valid = (mode_code != 3'h0);
    addr_16m = (mode_code == 3'h3) || (mode_code == 3'h4) || (mode_code == 3'h6);
    ext_bus_en = mode_valid && (mode_code != 3'h7);
    rom_enabled = (mode_code >= 3'h5);
    init_bus16 = (mode_code == 3'h2) || (mode_code == 3'h4);
    bus16_now = ext_bus_en && (area_width_config != 8'h00);
    ram_on = ram_enable || (mode_code == 3'h7);
  end
endmodule
`default_nettype wire

// File: design/msc_top.v
/*
 * Mode and system control register bank with AXI4-Lite slave, standby
 * settling-wait counter, priority interrupt edge detect and exception
 * flag helper.
 * Assumes the mode straps are static pins and the cpu supplies sleep and
 * exception strobes on clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "msc_consts.vh"
module msc_top #(
  parameter FLASH_BOOT_VARIANT = 0, // 1 on the single-supply flash part
  parameter WAIT_SCALE = 1 // divide settling counts for simulation
) (
  input wire clk, // system clock 125 MHz
  input wire rst, // async reset, active high
  input wire [2:0] mode_select_pins, // board straps
  input wire boot_mode, // flash boot mode level (pin)
  input wire priority_irq_pin, // priority interrupt pin
  input wire sleep_req, // cpu executed sleep, one-cycle pulse
  input wire wake_irq, // external interrupt wake, one-cycle pulse
  input wire exc_entry, // cpu begins interrupt/trap handling, pulse
  input wire [7:0] area_width_config, // area width bits from bus controller
  input wire [17:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [17:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  output wire [2:0] mode_num, // decoded mode
  output wire mode_valid, // strap legal
  output wire addr_16m, // 16 Mbyte address space
  output wire rom_enabled, // on-chip rom enabled
  output wire ext_bus_en, // external bus allowed
  output wire init_bus16, // initial bus 16 bits
  output wire bus16_now, // bus 16 bits now
  output wire ram_on, // on-chip ram active
  output reg sleep_active, // in sleep mode
  output reg standby_active, // in software standby
  output reg settling, // oscillator settling wait running
  output reg priority_irq_req, // pulse on selected edge
  output reg set_irq_mask, // pulse: set interrupt mask on exception
  output reg set_user_mask_flag, // pulse: also set user mask flag
  output wire user_mask_is_mask // user_mask_flag acts as interrupt mask
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts once stages two and three agree
  reg [2:0] mode_s1_reg, mode_s2_reg, mode_s3_reg, mode_stable_reg;
  reg [2:0] nmi_sync_reg;
  reg [2:0] boot_sync_reg;
  reg nmi_level_reg;
  reg boot_level_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_s1_reg <= 3'h0;
      mode_s2_reg <= 3'h0;
      mode_s3_reg <= 3'h0;
      mode_stable_reg <= 3'h0;
      nmi_sync_reg <= 3'h7;
      boot_sync_reg <= 3'h0;
      nmi_level_reg <= 1'b1;
      boot_level_reg <= 1'b0;
    end else begin
      mode_s1_reg <= mode_select_pins;
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
      if (mode_s2_reg == mode_s3_reg) begin
        mode_stable_reg <= mode_s3_reg;
      end
      nmi_sync_reg <= {nmi_sync_reg[1:0], priority_irq_pin};
      if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
        nmi_level_reg <= nmi_sync_reg[2];
      end
      boot_sync_reg <= {boot_sync_reg[1:0], boot_mode};
      if (boot_sync_reg[1] == boot_sync_reg[2]) begin
        boot_level_reg <= boot_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system control fields
  reg standby_select_reg;
  reg [2:0] settling_wait_field_reg;
  reg user_bit_enable_reg;
  reg priority_irq_edge_select_reg;
  reg ram_enable_reg;
  wire [7:0] sysctrl_value;
  assign sysctrl_value = {standby_select_reg, settling_wait_field_reg, user_bit_enable_reg,
    priority_irq_edge_select_reg, 1'b1, ram_enable_reg};
  assign user_mask_is_mask = ~user_bit_enable_reg;

  msc_mode_decode u_dec (
    .mode_code(mode_stable_reg),
    .ram_enable(ram_enable_reg),
    .area_width_config(area_width_config),
    .mode_num(mode_num),
    .mode_valid(mode_valid),
    .addr_16m(addr_16m),
    .rom_enabled(rom_enabled),
    .ext_bus_en(ext_bus_en),
    .init_bus16(init_bus16),
    .bus16_now(bus16_now),
    .ram_on(ram_on)
  );

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  reg aw_held_reg, w_held_reg;
  reg [17:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire aw_take, w_take, wr_go;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_go = aw_held_reg & w_held_reg;
  wire wr_sys;
  wire [17:0] wr_word;
  assign wr_word = {aw_addr_reg[17:2], 2'b00};
  assign wr_sys = wr_go && (wr_word == `MSC_ADDR_SYSCTRL) && w_strb_reg[0];
  // power status word is read-only: a write to it only earns an okay response
  wire wr_known;
  assign wr_known = (wr_word == `MSC_ADDR_SYSCTRL) || (wr_word == `MSC_ADDR_MODE_STATUS)
    || (wr_word == `MSC_ADDR_SLEEP_CTRL);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 18'h00000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // mode status write is accepted but has no effect
        s_axi_bresp <= wr_known ? `MSC_RESP_OKAY : `MSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes and power-down control
  reg [18:0] wait_cnt_reg;
  reg [18:0] wait_load;
  always @* begin
    case (settling_wait_field_reg)
      3'h0: wait_load = `MSC_WAIT_0;
      3'h1: wait_load = `MSC_WAIT_1;
      3'h2: wait_load = `MSC_WAIT_2;
      3'h3: wait_load = `MSC_WAIT_3;
      3'h4: wait_load = `MSC_WAIT_4;
      3'h5: wait_load = `MSC_WAIT_5;
      3'h6: wait_load = `MSC_WAIT_6;
      default: wait_load = `MSC_WAIT_5; // illegal code: longest legal wait, still ends
    endcase
  end
  wire [31:0] wait_div;
  wire [18:0] wait_scaled;
  assign wait_div = {13'h0000, wait_load} / WAIT_SCALE;
  assign wait_scaled = wait_div[18:0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_select_reg <= 1'b0;
      settling_wait_field_reg <= 3'h0;
      user_bit_enable_reg <= 1'b1;
      priority_irq_edge_select_reg <= 1'b0;
      ram_enable_reg <= 1'b1;
      sleep_active <= 1'b0;
      standby_active <= 1'b0;
      settling <= 1'b0;
      wait_cnt_reg <= 19'h00000;
    end else begin
      if (wr_sys) begin
        // bit 1 is never stored, so it keeps reading 1
        standby_select_reg <= w_data_reg[`MSC_BIT_STANDBY];
        settling_wait_field_reg <= w_data_reg[`MSC_BIT_WAIT_HI:`MSC_BIT_WAIT_LO];
        user_bit_enable_reg <= w_data_reg[`MSC_BIT_USER_EN];
        priority_irq_edge_select_reg <= w_data_reg[`MSC_BIT_EDGE];
        ram_enable_reg <= w_data_reg[`MSC_BIT_RAM_EN];
      end
      // standby entry and exit leave ram_enable and standby_select alone
      if (sleep_req && !sleep_active && !standby_active && !settling) begin
        if (standby_select_reg) begin
          standby_active <= 1'b1;
        end else begin
          sleep_active <= 1'b1;
        end
      end else if (wake_irq && sleep_active) begin
        sleep_active <= 1'b0;
      end else if (wake_irq && standby_active) begin
        standby_active <= 1'b0;
        settling <= 1'b1;
        wait_cnt_reg <= (wait_scaled == 19'h00000) ? 19'h00001 : wait_scaled;
      end else if (settling) begin
        wait_cnt_reg <= wait_cnt_reg - 19'h00001;
        if (wait_cnt_reg == 19'h00001) begin
          settling <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // priority interrupt edge and exception flag strobes
  reg nmi_prev_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_prev_reg <= 1'b1;
      priority_irq_req <= 1'b0;
      set_irq_mask <= 1'b0;
      set_user_mask_flag <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_level_reg;
      priority_irq_req <= priority_irq_edge_select_reg ? (nmi_level_reg & ~nmi_prev_reg)
        : (~nmi_level_reg & nmi_prev_reg);
      set_irq_mask <= exc_entry;
      set_user_mask_flag <= exc_entry & ~user_bit_enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel; mode pins latched when status is read
  wire [17:0] rd_word;
  wire [7:0] mode_status_value;
  wire status_top;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_word = {s_axi_araddr[17:2], 2'b00};
  // stable straps are assumed; a changing strap shows its latest agreed level
  assign status_top = (FLASH_BOOT_VARIANT != 0 && boot_level_reg) ? ~mode_stable_reg[2]
    : mode_stable_reg[2];
  assign mode_status_value = `MSC_MODE_STATUS_FIXED
    | {5'h00, status_top, mode_stable_reg[1:0]};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `MSC_RESP_OKAY;
      if (rd_word == `MSC_ADDR_MODE_STATUS) begin
        s_axi_rdata <= {24'h000000, mode_status_value};
      end else if (rd_word == `MSC_ADDR_SYSCTRL) begin
        s_axi_rdata <= {24'h000000, sysctrl_value};
      end else if (rd_word == `MSC_ADDR_SLEEP_CTRL) begin
        s_axi_rdata <= {29'h00000000, settling, standby_active, sleep_active};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `MSC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/msc_strap_model.sv
/* Board strap model: drives the three mode pins and the boot level.
   Assumes the bench changes the wanted code only while reset is held. */
`timescale 1ns/1ns
`default_nettype none
module msc_strap_model (
  input wire logic [2:0] code, // wanted mode
  input wire logic boot_level, // wanted boot strap
  output logic [2:0] mode_select_pins, // strap levels
  output logic boot_mode // boot strap level
);
  // straps are hard levels: they never float and never move in operation
  assign mode_select_pins = code;
  assign boot_mode = boot_level;
endmodule
`default_nettype wire

// File: sim/msc_checker_properties.sv
/* Checker for msc_top: mode decode, power entry and exception pulses.
   Assumes the clk and rst of the top; attached by the bind at the foot. */
`timescale 1ns/1ns
`default_nettype none
module msc_checker (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [2:0] mode_select_pins, // straps
  input wire logic [7:0] area_width_config, // area widths
  input wire logic sleep_req, // sleep pulse
  input wire logic exc_entry, // exception pulse
  input wire logic [2:0] mode_num, // mode
  input wire logic mode_valid, // legal strap
  input wire logic addr_16m, // big space
  input wire logic rom_enabled, // rom on
  input wire logic ext_bus_en, // external bus
  input wire logic init_bus16, // initial width
  input wire logic bus16_now, // width now
  input wire logic ram_on, // ram on
  input wire logic sleep_active, // sleep
  input wire logic standby_active, // standby
  input wire logic settling, // settling
  input wire logic set_irq_mask, // mask pulse
  input wire logic set_user_mask_flag, // user flag pulse
  input wire logic user_mask_is_mask // user flag is mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // six quiet cycles cover the pin synchroniser
  chk_mode_code: assert property ($stable(mode_select_pins)[*6]
    |-> mode_num == mode_select_pins)
    else $error("mode number differs from straps");
  chk_rom_use: assert property (mode_valid |-> rom_enabled == (mode_num >= 3'h5))
    else $error("rom enable wrong for mode");
  chk_addr_size: assert property (mode_valid
    |-> addr_16m == (mode_num inside {3'h3, 3'h4, 3'h6}))
    else $error("address size wrong for mode");
  chk_init_width: assert property (ext_bus_en
    |-> init_bus16 == (mode_num inside {3'h2, 3'h4}))
    else $error("initial bus width wrong");
  chk_bus_width: assert property (ext_bus_en && $stable(area_width_config)
    |-> bus16_now == (area_width_config != 8'h00))
    else $error("bus width ignores area settings");
  chk_ram_single: assert property (mode_num == 3'h7 |-> ram_on)
    else $error("ram off in single chip mode");
  chk_sleep_entry: assert property (sleep_req && !sleep_active
    && !standby_active && !settling |=> sleep_active != standby_active)
    else $error("sleep request entered no power state");
  chk_exc_flags: assert property (exc_entry
    |=> set_irq_mask && set_user_mask_flag == $past(user_mask_is_mask))
    else $error("exception flag pulses wrong");
endmodule
bind msc_top msc_checker msc_checker_i (.*);
`default_nettype wire

// File: sim/tb_mode_and_system_control.sv
/* Bench for msc_top: straps, registers over AXI4-Lite, power states, pulses.
   Assumes msc_consts.vh on the include path and WAIT_SCALE of 256. */
`timescale 1ns/1ns
`default_nettype none
`include "msc_consts.vh"
module tb_mode_and_system_control;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] code = 3'h1;
  logic bt = 1'h0;
  logic pin = 1'h1, slp = 1'h0, wak = 1'h0, exc = 1'h0;
  logic [7:0] awc = 8'h00;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire logic awready, wready, bvalid, arready, rvalid, boot, mval, a16, rom, ext, ib16, b16;
  wire logic ram, sa, sb, st, pirq, sim, suf, uim;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] pins, mnum;
  int err_count = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  msc_strap_model msc_strap_model_i (.code(code), .boot_level(bt), .mode_select_pins(pins),
    .boot_mode(boot));
  msc_top #(.FLASH_BOOT_VARIANT(1), .WAIT_SCALE(256)) msc_top_i (.clk(clk), .rst(rst),
    .mode_select_pins(pins),
    .boot_mode(boot), .priority_irq_pin(pin), .sleep_req(slp), .wake_irq(wak), .exc_entry(exc),
    .area_width_config(awc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode_num(mnum), .mode_valid(mval), .addr_16m(a16), .rom_enabled(rom), .ext_bus_en(ext),
    .init_bus16(ib16), .bus16_now(b16), .ram_on(ram), .sleep_active(sa), .standby_active(sb),
    .settling(st), .priority_irq_req(pirq), .set_irq_mask(sim), .set_user_mask_flag(suf),
    .user_mask_is_mask(uim));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // each channel is released on its own acceptance edge
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 100);
    while (!bvalid && n < 100) begin
      @(posedge clk);
      n++;
    end
    bready <= 1'h0;
    chk("bvalid", 1'h1, bvalid);
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'h0;
    while (!rvalid && n < 100) begin
      @(posedge clk);
      n++;
    end
    rready <= 1'h0;
    chk("rvalid", 1'h1, rvalid);
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", er, rresp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    for (int m = 7; m >= 1; m--) begin
      @(posedge clk);
      rst <= 1'h1;
      code <= m[2:0];
      bt <= (m == 5);
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
      chk("mode_num", m, mnum);
      chk("rom_enabled", m >= 5, rom);
      chk("addr_16m", m inside {3, 4, 6}, a16);
      chk("ext_bus_en", m != 7, ext);
      chk("mode_valid", 1'h1, mval);
      chk("bus16_now", 1'h0, b16);
      if (m < 7) chk("init_bus16", m == 2 || m == 4, ib16);
      rd(`MSC_ADDR_SYSCTRL, 8'h0B, `MSC_RESP_OKAY);
      // mode 5 runs with the boot strap up, so its top status bit reads inverted
      rd(`MSC_ADDR_MODE_STATUS, 8'hC0 | m[7:0] ^ {5'h00, m == 5, 2'h0},
        `MSC_RESP_OKAY);
      if (m == 7) begin
        wr(`MSC_ADDR_SYSCTRL, 8'h0A, `MSC_RESP_OKAY);
        chk("ram_on mode 7", 1'h1, ram);
      end
    end
  endtask
  task automatic t_regs;
    wr(`MSC_ADDR_SYSCTRL, 8'h0A, `MSC_RESP_OKAY);
    chk("ram_on", 1'h0, ram);
    awc <= 8'h10;
    repeat (2) @(posedge clk);
    chk("bus16_now", 1'h1, b16);
    awc <= 8'h00;
    wr(`MSC_ADDR_SYSCTRL, 8'h00, `MSC_RESP_OKAY);
    rd(`MSC_ADDR_SYSCTRL, 8'h02, `MSC_RESP_OKAY);
    wr(`MSC_ADDR_MODE_STATUS, 8'h3E, `MSC_RESP_OKAY);
    rd(`MSC_ADDR_MODE_STATUS, 8'hC1, `MSC_RESP_OKAY);
    wr(18'h00000, 8'hFF, `MSC_RESP_SLVERR);
    rd(18'h00000, 8'h00, `MSC_RESP_SLVERR);
  endtask
  // wait code 6 is 1024 states, scaled to 4 cycles; code 7 must still finish
  // the bench clock is a generator, not a crystal, so short waits are legal
  task automatic t_power;
    int n;
    for (int c = 6; c <= 8; c++) begin
      wr(`MSC_ADDR_SYSCTRL, (c == 8) ? 8'h0B : {1'h1, c[2:0], 4'hB}, `MSC_RESP_OKAY);
      slp <= 1'h1;
      @(posedge clk);
      slp <= 1'h0;
      @(posedge clk);
      chk("standby_active", c != 8, sb);
      chk("sleep_active", c == 8, sa);
      wak <= 1'h1;
      @(posedge clk);
      wak <= 1'h0;
      n = 0;
      #1;
      while (st && n < 2000) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (c == 6) chk("settling cycles", 4, n);
      chk("settling", 1'h0, st);
      chk("standby_active after wake", 1'h0, sb);
      chk("sleep_active after wake", 1'h0, sa);
      if (c < 8) rd(`MSC_ADDR_SYSCTRL, {1'h1, c[2:0], 4'hB}, `MSC_RESP_OKAY);
    end
  endtask
  task automatic t_edge(input logic [7:0] sc, input logic lvl, input int exp);
    int n;
    wr(`MSC_ADDR_SYSCTRL, sc, `MSC_RESP_OKAY);
    repeat (8) @(posedge clk);
    n = 0;
    pin <= lvl;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (pirq === 1'h1) n++;
    end
    chk("priority_irq_req pulses", exp, n);
  endtask
  task automatic t_exc(input logic [7:0] sc, input logic uf);
    wr(`MSC_ADDR_SYSCTRL, sc, `MSC_RESP_OKAY);
    exc <= 1'h1;
    @(posedge clk);
    exc <= 1'h0;
    #1;
    chk("set_irq_mask", 1'h1, sim);
    chk("set_user_mask_flag", uf, suf);
    chk("user_mask_is_mask", uf, uim);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    t_modes;
    t_regs;
    t_power;
    t_edge(8'h0B, 1'h0, 1);
    t_edge(8'h0B, 1'h1, 0);
    t_edge(8'h0F, 1'h0, 0);
    t_edge(8'h0F, 1'h1, 1);
    t_exc(8'h0B, 1'h0);
    t_exc(8'h03, 1'h1);
    print_verdict;
  end
  // the whole sequence needs under 3000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
